// File: ccrc_core_clock_reset.sv
// Functional notes
// R01: core clock comes from pll or input clock, chosen by the straps
// R02: straps 00=3:1, 01=16:1, 10=8:1, 11 reserved
// R03: straps set startup only; software may reprogram multiplier and divider later
// R04: shared pin defaults to reset out; control bit 12 selects pll clock
// R05: in reset-out mode the pin shows the core reset state
// R06: after reset release wait 4096 input clocks, then start at reset vector
// R07: external source holds reset low during power-up
// R08: input clock must run continuously at steady frequency
// R09: core reset and reset-out pin held through lock count, released together
`timescale 1ns/1ns
module ccrc_core_clock_reset
    import ccrc_pkg::*;
#(
    parameter int LOCK_CYCLES = ccrc_pkg::CCRC_LOCK_CYCLES
) (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_ce,
    input  wire logic [1:0]             i_ratio_select_straps,
    input  wire logic                   i_pll_clock,
    // wishbone classic slave
    input  wire logic                   i_wb_cyc,
    input  wire logic                   i_wb_stb,
    input  wire logic                   i_wb_we,
    input  wire logic [7:0]             i_wb_adr,
    input  wire logic [3:0]             i_wb_sel,
    input  wire logic [31:0]            i_wb_dat,
    output logic      [31:0]            o_wb_dat,
    output logic                        o_wb_ack,
    // core side
    output logic                        o_core_reset_n,
    output ccrc_pkg::ccrc_clk_cfg_s     o_clk_cfg,
    output logic                        o_reset_output_pin
);
    import ccrc_pkg::*;

    // refuse lock counts the 16-bit counter cannot hold; the strap capture
    // at count one needs a lock phase of at least two cycles
    if (LOCK_CYCLES < 2 || LOCK_CYCLES > 65535) begin : g_bad_lock
        $error("LOCK_CYCLES out of range");
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] strap_sync;
    logic       pll_sync;
    logic [2:0] sync_bus;

    // straps and pll clock share one synchroniser; the straps are static, so
    // only the pll clock ever sees a metastable first stage
    ccrc_sync2 #(.W(3)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_async   ({i_ratio_select_straps, i_pll_clock}),
        .o_sync    (sync_bus)
    );

    // split the synchronised bus back into its parts
    assign strap_sync = sync_bus[2:1];
    assign pll_sync   = sync_bus[0];

    // ************************************************************
    // strap decode
    // ************************************************************
    function automatic ccrc_clk_cfg_s strap_cfg(input logic [1:0] s);
        ccrc_clk_cfg_s c;
        c = '{use_pll: 1'b1, mult: CCRC_RATIO_3, div: CCRC_DIV_RST};
        case (s)
            CCRC_STRAP_3X:  c.mult = CCRC_RATIO_3;   // R02
            CCRC_STRAP_16X: c.mult = CCRC_RATIO_16;  // R02
            CCRC_STRAP_8X:  c.mult = CCRC_RATIO_8;   // R02
            default:        c.use_pll = 1'b0;        // R01
        endcase
        return c;
    endfunction

    // ************************************************************
    // sequencer
    // ************************************************************
    ccrc_state_e state_ff, nxt_state;
    logic [15:0] lock_cnt_ff;
    logic [15:0] nxt_lock_cnt;
    logic [1:0]  strap_ff;          // straps caught while held
    logic        core_rst_n_ff;
    logic        pin_sel_ff;        // control bit 12
    logic        sw_load_ff;
    logic [5:0]  mult_ff;
    logic [1:0]  div_ff;
    logic        wb_ack_ff;
    logic [31:0] wb_dat_ff;
    ccrc_clk_cfg_s clk_cfg_ff;
    logic        pin_ff;

    localparam logic [15:0] LOCK_LAST = 16'(LOCK_CYCLES - 1);

    // last count of the lock phase; the core leaves reset on the following edge
    wire lock_done = (lock_cnt_ff == LOCK_LAST);

    always_comb begin
        nxt_state    = state_ff;
        nxt_lock_cnt = lock_cnt_ff;
        case (state_ff)
            CCRC_ST_HOLD: begin
                nxt_state    = CCRC_ST_LOCK;
                nxt_lock_cnt = 16'h0000;
            end
            CCRC_ST_LOCK: begin
                nxt_lock_cnt = lock_cnt_ff + 16'h0001;
                if (lock_done) begin
                    nxt_state = CCRC_ST_RUN;                // R06
                end
            end
            CCRC_ST_RUN:  nxt_state = CCRC_ST_RUN;
            default:      nxt_state = CCRC_ST_HOLD;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff    <= CCRC_ST_HOLD;
            lock_cnt_ff <= 16'h0000;
        end else if (i_ce) begin
            state_ff    <= nxt_state;
            lock_cnt_ff <= nxt_lock_cnt;
        end
    end

    // catch straps at lock count one: by then they have passed both
    // synchroniser stages, and they are never taken while reset is low
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strap_ff <= CCRC_STRAP_3X;
        end else if (i_ce && state_ff == CCRC_ST_LOCK && lock_cnt_ff == 16'h0001) begin
            strap_ff <= strap_sync;                         // R01
        end
    end

    // core reset drops only when the lock count ends
    wire nxt_core_rst_n = (nxt_state == CCRC_ST_RUN);       // R09

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            core_rst_n_ff <= 1'b0;
        end else if (i_ce) begin
            core_rst_n_ff <= nxt_core_rst_n;                // R06
        end
    end

    // ************************************************************
    // register file
    // ************************************************************
    wire wb_req    = i_wb_cyc && i_wb_stb && !wb_ack_ff;
    wire wb_wr     = wb_req && i_wb_we;
    wire hit_power_clock_control_reg = (i_wb_adr == CCRC_POWER_CLOCK_CONTROL_REG_ADDR);
    wire hit_stat  = (i_wb_adr == CCRC_STATUS_ADDR);
    // ratio writes only once the core runs; earlier the straps rule
    wire pm_wr     = wb_wr && hit_power_clock_control_reg && core_rst_n_ff;   // R03

    wire [31:0] power_clock_control_reg_rd = (32'(mult_ff) << CCRC_MULT_LSB)
                         | (32'(div_ff) << CCRC_DIV_LSB)
                         | (32'(pin_sel_ff) << CCRC_CLKSEL_BIT)
                         | (32'(sw_load_ff) << CCRC_LOAD_BIT);
    wire [31:0] stat_rd  = {11'h000, state_ff, strap_ff, 16'(lock_cnt_ff)};
    wire [31:0] nxt_rd   = hit_power_clock_control_reg ? power_clock_control_reg_rd : (hit_stat ? stat_rd : 32'h0000_0000);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mult_ff    <= CCRC_MULT_RST;
            div_ff     <= CCRC_DIV_RST;
            pin_sel_ff <= 1'b0;                             // R04
            sw_load_ff <= 1'b0;
        end else if (i_ce && pm_wr) begin
            if (i_wb_sel[0]) mult_ff <= i_wb_dat[CCRC_MULT_LSB +: CCRC_MULT_W];
            if (i_wb_sel[1]) div_ff  <= i_wb_dat[CCRC_DIV_LSB +: CCRC_DIV_W];
            if (i_wb_sel[1]) pin_sel_ff <= i_wb_dat[CCRC_CLKSEL_BIT];   // R04
            if (i_wb_sel[2]) sw_load_ff <= i_wb_dat[CCRC_LOAD_BIT];     // R03
        end
    end

    // single-cycle answer; unmapped reads return zero, writes ignored
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wb_ack_ff <= 1'b0;
            wb_dat_ff <= 32'h0000_0000;
        end else if (i_ce) begin
            wb_ack_ff <= wb_req;
            wb_dat_ff <= nxt_rd;
        end
    end

    // ************************************************************
    // clock setting and shared pin
    // ************************************************************
    wire ccrc_clk_cfg_s sw_cfg  = '{use_pll: 1'b1, mult: mult_ff, div: div_ff};
    wire ccrc_clk_cfg_s nxt_cfg = (core_rst_n_ff && sw_load_ff) ? sw_cfg   // R03
                                                               : strap_cfg(strap_ff); // R01
    // clock out is the pll clock as sampled by the system clock, so it is a
    // coarse copy good only for pll clocks well below half the system rate
    // pin mirrors core reset unless clock out selected; during lock the reset
    // is shown whatever the select, so the pin and core leave reset together
    wire nxt_pin = (pin_sel_ff && nxt_core_rst_n) ? pll_sync        // R04
                                                  : nxt_core_rst_n; // R05 R09

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clk_cfg_ff <= '{use_pll: 1'b1, mult: CCRC_RATIO_3, div: CCRC_DIV_RST};
            pin_ff     <= 1'b0;
        end else if (i_ce) begin
            clk_cfg_ff <= nxt_cfg;
            pin_ff     <= nxt_pin;
        end
    end

    // every output is a flop, so nothing downstream sees a decode glitch
    assign o_wb_ack           = wb_ack_ff;
    assign o_wb_dat           = wb_dat_ff;
    assign o_core_reset_n     = core_rst_n_ff;
    assign o_clk_cfg          = clk_cfg_ff;
    assign o_reset_output_pin = pin_ff;

endmodule // ccrc_core_clock_reset

// File: ccrc_pkg.sv
package ccrc_pkg;

    // ************************************************************
    // register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] CCRC_POWER_CLOCK_CONTROL_REG_ADDR  = 8'h00;   // power_clock_control_reg
    localparam logic [7:0] CCRC_STATUS_ADDR = 8'h04;   // read-only state

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int         CCRC_MULT_LSB    = 0;
    localparam int         CCRC_MULT_W      = 6;
    localparam int         CCRC_DIV_LSB     = 8;
    localparam int         CCRC_DIV_W       = 2;
    localparam int         CCRC_CLKSEL_BIT  = 12;      // pin function select
    localparam int         CCRC_LOAD_BIT    = 16;      // software ratio takes over
    localparam logic [5:0] CCRC_MULT_RST    = 6'h03;
    localparam logic [1:0] CCRC_DIV_RST     = 2'h0;

    // ************************************************************
    // strap codes and startup ratios
    // ************************************************************
    localparam logic [1:0] CCRC_STRAP_3X    = 2'h0;
    localparam logic [1:0] CCRC_STRAP_16X   = 2'h1;
    localparam logic [1:0] CCRC_STRAP_8X    = 2'h2;
    localparam logic [5:0] CCRC_RATIO_3     = 6'h03;
    localparam logic [5:0] CCRC_RATIO_16    = 6'h10;
    localparam logic [5:0] CCRC_RATIO_8     = 6'h08;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int         CCRC_LOCK_CYCLES = 4096;    // input clock cycles to lock

    // clock setting handed to the clock generator
    typedef struct packed {
        logic       use_pll;   // 0: core runs straight from the input clock
        logic [5:0] mult;
        logic [1:0] div;
    } ccrc_clk_cfg_s;

    typedef enum logic [2:0] {
        CCRC_ST_HOLD = 3'b001,
        CCRC_ST_LOCK = 3'b010,
        CCRC_ST_RUN  = 3'b100
    } ccrc_state_e;

endpackage

// File: ccrc_sync2.sv
`timescale 1ns/1ns
// two-flop synchroniser for asynchronous pin inputs
module ccrc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;

    // first stage is read by the second stage only
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_ff <= '0;
            o_sync  <= '0;
        end else if (i_ce) begin
            meta_ff <= i_async;
            o_sync  <= meta_ff;
        end
    end
endmodule // ccrc_sync2

// File: ccrc_board_model.sv
`timescale 1ns/1ns
// ********************
// board: reset source and pll clock
// ********************
module ccrc_board_model (
    input  wire logic i_rst_req,
    output logic      o_reset_n,
    output logic      o_pll_clock
);
    // reset line is low whenever asked; the bench asks from time zero
    assign o_reset_n = !i_rst_req;
    // free-running clock; odd half period keeps it unrelated to the system clock
    initial o_pll_clock = 1'b0;
    always #7 o_pll_clock = ~o_pll_clock;
endmodule // ccrc_board_model

// File: ccrc_core_clock_reset_properties.sv
`timescale 1ns/1ns
// ********************
// checker on the top-level pins
// ********************
module ccrc_core_clock_reset_properties
    import ccrc_pkg::*;
#(
    parameter int LOCK_CYCLES = CCRC_LOCK_CYCLES
) (
    input wire logic                    i_sys_clk,
    input wire logic                    i_reset_n,
    input wire logic                    i_ce,
    input wire logic [1:0]              i_ratio_select_straps,
    input wire logic                    i_wb_cyc,
    input wire logic                    i_wb_stb,
    input wire logic                    o_wb_ack,
    input wire logic                    o_core_reset_n,
    input wire ccrc_pkg::ccrc_clk_cfg_s o_clk_cfg,
    input wire logic                    o_reset_output_pin
);
    logic [15:0] since_ff;
    wire  [15:0] lock_end = 16'(LOCK_CYCLES + 1);
    wire  [15:0] nxt_since = (since_ff >= lock_end) ? since_ff : since_ff + 16'h0001;
    wire  [1:0]  s = i_ratio_select_straps;
    wire  [8:0]  exp_cfg = (s == CCRC_STRAP_16X) ? {1'b1, CCRC_RATIO_16, 2'h0} :
                           (s == CCRC_STRAP_8X) ? {1'b1, CCRC_RATIO_8, 2'h0} :
                           {s != 2'h3, CCRC_RATIO_3, 2'h0};
    // edges since release; saturates so a long run cannot wrap it
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            since_ff <= 16'h0000;
        else if (i_ce)
            since_ff <= nxt_since;
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    property p_lock_hold;
        since_ff < lock_end |-> !o_core_reset_n;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("core released early");
    property p_release_at;
        $rose(o_core_reset_n) |-> since_ff == lock_end;
    endproperty
    a_release_at: assert property (p_release_at)
        else $error("core released at wrong count");
    property p_pin_low;
        !o_core_reset_n |-> !o_reset_output_pin;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("pin high while core held");
    property p_together;
        $rose(o_core_reset_n) |-> o_reset_output_pin;
    endproperty
    a_together: assert property (p_together)
        else $error("pin not released with core");
    property p_strap_cfg;
        since_ff > 16'h0003 && !o_core_reset_n |-> o_clk_cfg == exp_cfg;
    endproperty
    a_strap_cfg: assert property (p_strap_cfg)
        else $error("startup clock setting wrong");
    property p_ack_one;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack longer than one cycle");
    property p_ack_answer;
        i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("request not answered");
    property p_ack_cause;
        o_wb_ack |-> $past(i_wb_cyc && i_wb_stb);
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    c_release: cover property ($rose(o_core_reset_n));
    c_ack: cover property (o_wb_ack);
    c_clock_out: cover property (o_core_reset_n && $changed(o_reset_output_pin));
endmodule // ccrc_core_clock_reset_properties
bind ccrc_core_clock_reset ccrc_core_clock_reset_properties #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_ce(i_ce),
    .i_ratio_select_straps(i_ratio_select_straps), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack), .o_core_reset_n(o_core_reset_n), .o_clk_cfg(o_clk_cfg),
    .o_reset_output_pin(o_reset_output_pin));

// File: test_core_clock_reset_control.sv
`timescale 1ns/1ns
module test_core_clock_reset_control;
    import ccrc_pkg::*;
    localparam int LOCK = 8;
    logic          i_sys_clk = 1'b0, rst_req = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [1:0]    straps = 2'h0;
    logic          ce = 1'b1;
    logic [3:0]    sel = 4'hf, wsel = 4'hf;
    logic [7:0]    adr = 8'h00;
    logic [31:0]   wdat = 32'h0, rdat, q;
    wire           reset_n, pll_clock, core_reset_n, ack, pin;
    ccrc_clk_cfg_s cfg;
    int            n_fail = 0, compares = 0, n, ones;
    always #10 i_sys_clk = ~i_sys_clk;
    ccrc_board_model board (.i_rst_req(rst_req), .o_reset_n(reset_n), .o_pll_clock(pll_clock));
    ccrc_core_clock_reset #(.LOCK_CYCLES(LOCK)) dut (.i_sys_clk(i_sys_clk), .i_reset_n(reset_n),
        .i_ce(ce), .i_ratio_select_straps(straps), .i_pll_clock(pll_clock), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_core_reset_n(core_reset_n), .o_clk_cfg(cfg),
        .o_reset_output_pin(pin));
    task automatic conclude();
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("BAD at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // startup setting per strap code, worked out from the package constants
    function automatic logic [8:0] dec(input logic [1:0] s);
        case (s)
            CCRC_STRAP_3X:  dec = {1'b1, CCRC_RATIO_3, 2'h0};
            CCRC_STRAP_16X: dec = {1'b1, CCRC_RATIO_16, 2'h0};
            CCRC_STRAP_8X:  dec = {1'b1, CCRC_RATIO_8, 2'h0};
            default:        dec = {1'b0, CCRC_RATIO_3, 2'h0};
        endcase
    endfunction
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= wsel;
        k = 0;
        do begin
            @(posedge i_sys_clk);
            k++;
            if (k > 50) begin
                n_fail++;
                conclude();
            end
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic hold_reset(input logic [1:0] s);
        @(posedge i_sys_clk);
        straps <= s;
        rst_req <= 1'b1;
        repeat (5) @(posedge i_sys_clk);
        rst_req <= 1'b0;
    endtask
    // counts edges from the call until the core runs
    task automatic wait_run();
        n = 0;
        while (core_reset_n !== 1'b1) begin
            @(posedge i_sys_clk);
            n++;
            if (n > 100) begin
                n_fail++;
                conclude();
            end
        end
    endtask
    task automatic t_straps();
        for (int s = 0; s < 4; s++) begin
            hold_reset(2'(s));
            wait_run();
            chk(LOCK + 2, n);
            chk(dec(2'(s)), cfg);
            chk(1, pin);
        end
        $display("straps test done");
    endtask
    // clock enable low freezes the sequencer; the lock count starts when it rises
    task automatic t_freeze();
        hold_reset(CCRC_STRAP_8X);
        ce <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        ce <= 1'b1;
        wait_run();
        chk(LOCK + 2, n);
        chk(dec(CCRC_STRAP_8X), cfg);
        $display("freeze test done");
    endtask
    task automatic t_regs();
        hold_reset(CCRC_STRAP_16X);
        wb(1'b1, CCRC_POWER_CLOCK_CONTROL_REG_ADDR, 32'h0001_0205);
        wait_run();
        chk(dec(CCRC_STRAP_16X), cfg);
        wb(1'b0, CCRC_POWER_CLOCK_CONTROL_REG_ADDR, 32'h0);
        chk({CCRC_DIV_RST, 2'h0, CCRC_MULT_RST}, q[15:0]);
        wb(1'b1, CCRC_POWER_CLOCK_CONTROL_REG_ADDR, 32'h0001_0205);
        @(posedge i_sys_clk);
        chk({1'b1, 6'h05, 2'h2}, cfg);
        wb(1'b0, CCRC_STATUS_ADDR, 32'h0);
        chk({3'b100, CCRC_STRAP_16X}, q[20:16]);
        wb(1'b1, 8'h08, 32'hffff_ffff);
        wb(1'b0, 8'h08, 32'h0);
        chk(0, q);
        wb(1'b0, CCRC_POWER_CLOCK_CONTROL_REG_ADDR, 32'h0);
        chk(16'h0205, q[15:0]);
        // byte lane 0 alone: only the multiplier may move
        wsel = 4'h1;
        wb(1'b1, CCRC_POWER_CLOCK_CONTROL_REG_ADDR, 32'h0000_1f3e);
        wsel = 4'hf;
        wb(1'b0, CCRC_POWER_CLOCK_CONTROL_REG_ADDR, 32'h0);
        chk(32'h0001_023e, q);
        $display("register test done");
    endtask
    task automatic t_pin();
        wb(1'b1, CCRC_POWER_CLOCK_CONTROL_REG_ADDR, 32'h0001_1205);
        ones = 0;
        repeat (32) begin
            @(posedge i_sys_clk);
            ones += int'(pin === 1'b1);
        end
        chk(1, ones > 0 && ones < 32);
        wb(1'b1, CCRC_POWER_CLOCK_CONTROL_REG_ADDR, 32'h0001_0205);
        repeat (4) @(posedge i_sys_clk);
        chk(1, pin);
        $display("pin test done");
    endtask
    initial begin
        repeat (5) @(posedge i_sys_clk);
        rst_req <= 1'b0;
        wait_run();
        chk(LOCK + 2, n);
        t_straps();
        t_freeze();
        t_regs();
        t_pin();
        conclude();
    end
endmodule // test_core_clock_reset_control
